// ---- core/nvws_top.sv ----
// nvram and watchdog service engine with wishbone register access
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module nvws_top
    import nvws_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = WDOG_CYC,
    parameter int unsigned XFER_CYCLES = XFER_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack,
    output logic             wdt_reset
);
    localparam int unsigned WDW = $clog2(WDOG_CYCLES);
    localparam int unsigned TMW = $clog2(XFER_CYCLES);

    logic              ack_q;
    logic              pend_q;
    logic [31:0]       dat_q;
    logic [31:0]       cmd_q;
    nvws_state_t       st_q;
    nvws_state_t       st_d;
    logic [7:0]        op_q;
    logic [5:0]        ptr_q;
    logic [6:0]        left_q;
    logic [7:0]        done_q;
    logic [7:0]        res_q;
    logic [7:0]        res_d;
    logic [7:0]        info_q;
    logic [7:0]        info_d;
    logic              wren_q;
    logic              wren_d;
    logic              wd_en_q;
    logic [WDW-1:0]    wd_cnt_q;
    logic              wdt_q;
    logic [TMW-1:0]    tmo_q;
    logic              cmp_v_q;
    logic [15:0]       cmp_w_q;
    logic [15:0]       mem_rd;

    // bus decode
    wire        req      = wb_cyc & wb_stb & ~ack_q & ~pend_q;
    wire        bus_wr   = req & wb_we;
    wire        bus_rd   = req & ~wb_we;
    wire        hit_cmd  = wb_adr[7:2] == ADR_CMD[7:2];
    wire        hit_data = wb_adr[7:2] == ADR_DATA[7:2];
    wire        hit_stat = wb_adr[7:2] == ADR_STAT[7:2];
    wire        sel_all  = wb_sel == 4'hF;
    wire        sel_lo   = wb_sel[1:0] == 2'b11;
    wire        srst     = wdt_q;  // watchdog bite clears the engine

    // command fields
    wire [7:0]  fc       = wb_dat_i[CMD_FC +: 8];
    wire [7:0]  ad       = wb_dat_i[CMD_AD +: 8];
    wire [15:0] cnt      = wb_dat_i[CMD_CNT +: 16];
    wire        idle     = st_q == ST_IDLE;
    wire        xfer     = st_q == ST_XFER;
    wire        cmd_go   = bus_wr & hit_cmd & sel_all;
    wire        wd_go    = cmd_go & nvws_is_wd(fc);
    // store commands while busy are dropped; only the watchdog acts
    wire        nv_go    = cmd_go & idle & ~nvws_is_wd(fc);

    // start checks
    wire [16:0] end_sum  = {9'h000, ad} + {1'b0, cnt};
    wire        legal    = (fc <= FC_ERASE);
    wire        bad_rng  = (ad > NV_LAST) | (end_sum > NV_END);
    wire        rsv      = ad < NV_USER;
    wire        io       = nvws_is_io(fc);
    wire        modf     = nvws_is_mod(fc);
    wire [7:0]  chk_res  =
        !legal                ? RES_ILL  :
        (io & bad_rng)        ? RES_ADDR :
        (modf & rsv)          ? RES_RSVD :
        (modf & ~wren_q)      ? RES_ILL  :
        RES_OK;
    wire        run      = nv_go & io & (chk_res == RES_OK) & (cnt != 16'h0000);

    // word movement during a session
    wire        d_ok     = xfer & hit_data & ~cmp_v_q;
    wire        dat_rd   = bus_rd & d_ok & (op_q == FC_READ);
    wire        wr_word  = bus_wr & d_ok & sel_lo & (op_q == FC_WRITE);
    wire        ver_iss  = bus_wr & d_ok & sel_lo & (op_q == FC_VERIF);
    wire        erasing  = st_q == ST_ERASE;
    wire        miss     = cmp_v_q & (mem_rd != cmp_w_q);
    wire        cmp_ok   = cmp_v_q & ~miss;
    wire        step     = erasing | wr_word | dat_rd;
    wire        adv      = step | cmp_ok;
    wire        last     = left_q == 7'h01;
    wire        tmo_hit  = xfer & ~cmp_v_q & (tmo_q == TMW'(XFER_CYCLES - 1));
    wire        wd_bite  = wd_en_q & (wd_cnt_q == WDW'(WDOG_CYCLES - 1));

    // store port: erase writes the erased pattern, writes take bus data
    wire        mem_we   = (erasing | wr_word) & wren_q;
    wire        mem_re   = dat_rd | ver_iss;
    wire [15:0] mem_wd   = erasing ? NV_ERASED : wb_dat_i[15:0];

    // status word and read mux
    wire [31:0] stat_w   = {13'h0000, wd_en_q, wren_q, ~idle, info_q, res_q};
    wire [31:0] rd_mux   = hit_stat ? stat_w :
                           hit_cmd  ? cmd_q  : 32'h00000000;

    nvws_mem #(
        .AW (NV_AW),
        .DW (NV_DW)
    ) u_mem (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .we      (mem_we),
        .re      (mem_re),
        .addr    (ptr_q),
        .wdata   (mem_wd),
        .rdata_q (mem_rd)
    );

    // session state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (run) begin
                    st_d = (fc == FC_ERASE) ? ST_ERASE : ST_XFER;
                end
            end
            ST_ERASE: begin
                if (last) begin
                    st_d = ST_IDLE;
                end
            end
            ST_XFER: begin
                if ((adv & last) | miss | tmo_hit) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // result code and companion byte
    always_comb begin
        res_d  = res_q;
        info_d = info_q;
        if (nv_go) begin
            res_d  = chk_res;
            info_d = 8'h00;
        end else if (adv & last) begin
            res_d  = RES_OK;
            info_d = done_q + 8'h01;
        end else if (miss) begin
            res_d  = RES_VER;
            info_d = {2'b00, ptr_q};
        end else if (tmo_hit) begin
            res_d  = RES_TMO;
            info_d = done_q;
        end
    end

    // permission state
    always_comb begin
        wren_d = wren_q;
        if (nv_go && fc == FC_WREN) begin
            wren_d = 1'b1;
        end else if (nv_go && fc == FC_WRDIS) begin
            wren_d = 1'b0;
        end
    end

    // engine registers, cleared by reset or by a watchdog bite
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q   <= ST_IDLE;
            res_q  <= RES_OK;
            info_q <= 8'h00;
            wren_q <= 1'b0;
        end else if (srst) begin
            st_q   <= ST_IDLE;
            res_q  <= RES_OK;
            info_q <= 8'h00;
            wren_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            res_q  <= res_d;
            info_q <= info_d;
            wren_q <= wren_d;
        end
    end

    // word pointer, words left and words done
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            op_q   <= 8'h00;
            ptr_q  <= 6'h00;
            left_q <= 7'h00;
            done_q <= 8'h00;
        end else if (run) begin
            op_q   <= fc;
            ptr_q  <= ad[5:0];
            left_q <= cnt[6:0];
            done_q <= 8'h00;
        end else if (adv) begin
            ptr_q  <= ptr_q + 6'h01;
            left_q <= left_q - 7'h01;
            done_q <= done_q + 8'h01;
        end
    end

    // verify compare one cycle after the store read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmp_v_q <= 1'b0;
            cmp_w_q <= 16'h0000;
        end else begin
            cmp_v_q <= ver_iss & ~srst;
            if (ver_iss) begin
                cmp_w_q <= wb_dat_i[15:0];
            end
        end
    end

    // idle timer of a session waiting on the bus
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tmo_q <= '0;
        end else if (!xfer || srst || (req && hit_data) || tmo_hit) begin
            tmo_q <= '0;
        end else begin
            tmo_q <= tmo_q + TMW'(1);
        end
    end

    // watchdog; enable also restarts the count so it never bites early
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wd_en_q  <= 1'b0;
            wd_cnt_q <= '0;
            wdt_q    <= 1'b0;
        end else begin
            wdt_q <= wd_bite;
            if (srst || (wd_go && fc == FC_WD_OF)) begin
                wd_en_q <= 1'b0;
            end else if (wd_go && fc == FC_WD_ON) begin
                wd_en_q <= 1'b1;
            end
            if (!wd_en_q || wd_bite || (wd_go && fc != FC_WD_OF)) begin
                wd_cnt_q <= '0;
            end else begin
                wd_cnt_q <= wd_cnt_q + WDW'(1);
            end
        end
    end

    // bus answer: one cycle, two for a store read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q  <= 1'b0;
            pend_q <= 1'b0;
            dat_q  <= 32'h00000000;
            cmd_q  <= CMD_RST;
        end else begin
            ack_q  <= (req & ~dat_rd) | pend_q;
            pend_q <= dat_rd;
            if (pend_q) begin
                dat_q <= {16'h0000, mem_rd};
            end else if (bus_rd) begin
                dat_q <= rd_mux;
            end
            if (cmd_go) begin
                cmd_q <= wb_dat_i;
            end
        end
    end

    assign wb_ack    = ack_q;
    assign wb_dat_o  = dat_q;
    assign wdt_reset = wdt_q;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn || wdt_q);

    a_ack_single: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
    a_guard_lower: assert property (
            mem_we |-> ptr_q[5] && wren_q)
        else $error("store write outside open half or without permission");
    a_perm_set: assert property (
            nv_go && fc == FC_WREN |=> wren_q && res_q == RES_OK)
        else $error("enable did not set permission");
    a_perm_clear: assert property (
            nv_go && fc == FC_WRDIS |=> !wren_q)
        else $error("disable did not clear permission");
    a_mod_refused: assert property (
            nv_go && modf && !wren_q |=> res_q != RES_OK && st_q == ST_IDLE)
        else $error("modify ran without permission");
    // range check comes first, so only in-range reserved targets apply
    a_rsvd_code: assert property (
            nv_go && modf && rsv && !bad_rng |=> res_q == RES_RSVD)
        else $error("reserved target not refused");
    a_illegal_code: assert property (
            nv_go && !legal |=> res_q == RES_ILL && info_q == 8'h00)
        else $error("unknown code not illegal");
    a_range_code: assert property (
            nv_go && io && bad_rng |=> res_q == RES_ADDR)
        else $error("overrun not invalid address");
    a_verify_fail: assert property (
            miss |=> res_q == RES_VER && info_q == {2'b00, $past(ptr_q)})
        else $error("mismatch not reported");
    a_read_free: assert property (
            nv_go && fc == FC_READ && !bad_rng && cnt != 16'h0000
            |=> st_q == ST_XFER && res_q == RES_OK)
        else $error("read needed permission");
    a_data_lat: assert property (dat_rd |=> !ack_q ##1 ack_q)
        else $error("store read answer not two cycles");
    // a bite raises wdt_q, so the default disable would hide these three
    a_wd_bite: assert property (
            disable iff (!resetn)
            wd_en_q && wd_cnt_q == WDW'(WDOG_CYCLES - 1) && !wd_go
            |=> wdt_reset)
        else $error("watchdog did not bite");
    a_wd_after: assert property (
            disable iff (!resetn)
            wd_bite |=> wdt_q ##1 (!wd_en_q && !wren_q && st_q == ST_IDLE))
        else $error("bite did not clear engine");
    a_wd_quiet: assert property (
            disable iff (!resetn)
            !wd_en_q |=> !wdt_reset)
        else $error("bite while disabled");

    c_read_done: cover property (dat_rd && last);
    c_verify_miss: cover property (miss);
    c_erase_run: cover property (erasing ##1 erasing);
    c_wd_bite: cover property (wdt_q);
endmodule : nvws_top

// ---- core/nvws_pkg.sv ----
// constants and types of the nvram and watchdog service block
package nvws_pkg;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned WDOG_TMO_MS = 1200;
    localparam int unsigned WDOG_CYC    = WDOG_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned XFER_TMO_MS = 10;
    localparam int unsigned XFER_CYC    = XFER_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned NV_AW       = 6;
    localparam int unsigned NV_DW       = 16;
    localparam logic [7:0]  NV_USER     = 8'h20;
    localparam logic [7:0]  NV_LAST     = 8'h3F;
    localparam logic [16:0] NV_END      = 17'h00040;
    localparam logic [15:0] NV_ERASED   = 16'hFFFF;
    // function codes
    localparam logic [7:0] FC_WREN  = 8'h00;
    localparam logic [7:0] FC_WRDIS = 8'h01;
    localparam logic [7:0] FC_READ  = 8'h02;
    localparam logic [7:0] FC_WRITE = 8'h03;
    localparam logic [7:0] FC_VERIF = 8'h04;
    localparam logic [7:0] FC_ERASE = 8'h05;
    localparam logic [7:0] FC_WD_ON = 8'h0C;
    localparam logic [7:0] FC_WD_OF = 8'h0D;
    localparam logic [7:0] FC_WD_RF = 8'h0E;
    // result codes
    localparam logic [7:0] RES_OK   = 8'h00;
    localparam logic [7:0] RES_RSVD = 8'h10;
    localparam logic [7:0] RES_ADDR = 8'h20;
    localparam logic [7:0] RES_ILL  = 8'h40;
    localparam logic [7:0] RES_TMO  = 8'h80;
    localparam logic [7:0] RES_VER  = 8'hFF;
    // register byte offsets and fields
    localparam logic [7:0] ADR_CMD  = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam int unsigned CMD_FC  = 0;
    localparam int unsigned CMD_AD  = 8;
    localparam int unsigned CMD_CNT = 16;
    localparam logic [31:0] CMD_RST = 32'h00000000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_XFER  = 3'b100
    } nvws_state_t;

    function automatic logic nvws_is_wd(input logic [7:0] fc);
        return (fc == FC_WD_ON) || (fc == FC_WD_OF) || (fc == FC_WD_RF);
    endfunction : nvws_is_wd

    function automatic logic nvws_is_io(input logic [7:0] fc);
        return (fc >= FC_READ) && (fc <= FC_ERASE);
    endfunction : nvws_is_io

    function automatic logic nvws_is_mod(input logic [7:0] fc);
        return (fc == FC_WRITE) || (fc == FC_ERASE);
    endfunction : nvws_is_mod
endpackage : nvws_pkg

// ---- core/nvws_mem.sv ----
// word store of the nvram service with registered read data
`timescale 1ns/100ps
module nvws_mem
    import nvws_pkg::*;
#(
    parameter int unsigned AW = NV_AW,
    parameter int unsigned DW = NV_DW
) (
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata_q
);
    logic [DW-1:0] mem_q [2**AW];

    // array has no reset so contents survive every module reset
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
    end

    // read port
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (re) begin
            rdata_q <= mem_q[addr];
        end
    end
endmodule : nvws_mem

// ---- bench/nvws_host.sv ----
// wishbone classic master standing in for the host service software
`timescale 1ns/100ps
module nvws_host (
    input  wire logic        clk_sys,
    output logic             wb_cyc,
    output logic             wb_stb,
    output logic             wb_we,
    output logic [7:0]       wb_adr,
    output logic [3:0]       wb_sel,
    output logic [31:0]      wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack
);
    // idle bus at time zero
    initial begin
        wb_cyc   = 1'b0;
        wb_stb   = 1'b0;
        wb_we    = 1'b0;
        wb_adr   = 8'h00;
        wb_sel   = 4'hF;
        wb_dat_i = 32'h00000000;
    end

    // one classic cycle; ack and read data are taken at the rising edge
    // that samples ack high, and only then is the request released
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, output logic [31:0] rd,
                       input logic [3:0] sel = 4'hF);
        @(posedge clk_sys);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_sys); while (wb_ack !== 1'b1);
        rd = wb_dat_o;
        wb_cyc   <= 1'b0;
        wb_stb   <= 1'b0;
        wb_we    <= 1'b0;
        wb_dat_i <= ~dat; // released data does not keep its last value
    endtask : bus
endmodule : nvws_host

// ---- bench/nvws_test.sv ----
// self-checking bench of the nvram and watchdog service block
`timescale 1ns/100ps
module nvws_test;
    import nvws_pkg::*;
    localparam int unsigned WDC = 200; // short watchdog for simulation
    localparam int unsigned XFC = 64;  // short session timeout
    typedef struct packed {
        logic [7:0]  fc;
        logic [7:0]  ad;
        logic [15:0] cnt;
        logic [7:0]  res;
        logic        perm;
    } nvws_row_t;
    // command start checks, in order, with the permission they leave
    localparam nvws_row_t ROWS [12] = '{
        '{8'h07, 8'h00, 16'h0001, RES_ILL, 1'b0},
        '{FC_READ, 8'h40, 16'h0001, RES_ADDR, 1'b0},
        '{FC_READ, 8'h3F, 16'h0002, RES_ADDR, 1'b0},
        '{FC_VERIF, 8'h41, 16'h0001, RES_ADDR, 1'b0},
        '{FC_WRITE, 8'h20, 16'h0001, RES_ILL, 1'b0},
        '{FC_ERASE, 8'h30, 16'h0001, RES_ILL, 1'b0},
        '{FC_WREN, 8'h00, 16'h0000, RES_OK, 1'b1},
        '{FC_WRITE, 8'h1F, 16'h0001, RES_RSVD, 1'b1},
        '{FC_ERASE, 8'h00, 16'h0001, RES_RSVD, 1'b1},
        '{FC_ERASE, 8'h3F, 16'h0002, RES_ADDR, 1'b1},
        '{FC_READ, 8'h3F, 16'h0000, RES_OK, 1'b1},
        '{FC_WRDIS, 8'h00, 16'h0000, RES_OK, 1'b0}
    };
    logic        clk_sys = 1'b0;
    logic        resetn  = 1'b0;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack;
    logic        wdt_reset;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    int          bites      = 0;

    always #5 clk_sys = ~clk_sys;

    nvws_top #(.WDOG_CYCLES(WDC), .XFER_CYCLES(XFC)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
        .wdt_reset(wdt_reset));
    nvws_host host (
        .clk_sys(clk_sys), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack));

    // bite pulses and the hang limit
    always @(posedge clk_sys) begin
        cycles++;
        if (wdt_reset === 1'b1) bites++;
        if (cycles == 8000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] fc, input logic [7:0] ad,
                       input logic [15:0] cnt);
        logic [31:0] r;
        host.bus(1'b1, ADR_CMD, {cnt, ad, fc}, r);
    endtask : cmd

    task automatic stat(output logic [31:0] s);
        host.bus(1'b0, ADR_STAT, 32'h00000000, s);
    endtask : stat

    task automatic dwr(input logic [15:0] w);
        logic [31:0] r;
        host.bus(1'b1, ADR_DATA, {16'h0000, w}, r);
    endtask : dwr

    task automatic drd(input logic [15:0] exp);
        logic [31:0] r;
        host.bus(1'b0, ADR_DATA, 32'h00000000, r);
        chk(32'(r[15:0]), 32'(exp));
    endtask : drd

    task automatic conclude();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        logic [31:0] s;
        logic [31:0] r;
        int          n;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        stat(s);
        chk(s, 32'h00000000);
        host.bus(1'b0, 8'h0C, 32'h00000000, r);
        chk(r, 32'h00000000);
        for (int i = 0; i < 12; i++) begin
            cmd(ROWS[i].fc, ROWS[i].ad, ROWS[i].cnt);
            stat(s);
            chk(32'({s[17:16], s[7:0]}), 32'({ROWS[i].perm, 1'b0,
                ROWS[i].res}));
        end
        // a command word without all byte lanes is not taken
        host.bus(1'b1, ADR_CMD, {16'h0001, 8'h20, FC_READ}, r, 4'h3);
        stat(s);
        chk(32'(s[17:0]), 32'h00000000);
        host.bus(1'b0, ADR_CMD, 32'h00000000, r);
        chk(r, {16'h0000, 8'h00, FC_WRDIS});
        // full modify cycle: enable, erase, write, disable, verify
        cmd(FC_WREN, 8'h00, 16'h0000);
        cmd(FC_ERASE, 8'h20, 16'h0003);
        n = 0;
        do begin
            stat(s);
            n++;
        end while (s[16] !== 1'b0 && n < 20);
        chk(32'(s[15:0]), 32'h00000300);
        // each open word is written only a few times in the whole run
        cmd(FC_WRITE, 8'h20, 16'h0002);
        dwr(16'hA5A5);
        dwr(16'h5A5A);
        stat(s);
        chk(32'(s[17:0]), 32'h00020200);
        cmd(FC_WRDIS, 8'h00, 16'h0000);
        cmd(FC_VERIF, 8'h20, 16'h0002);
        dwr(16'hA5A5);
        dwr(16'h5A5A);
        stat(s);
        chk(32'(s[17:0]), 32'h00000200);
        // a mismatch on the second word names its address
        cmd(FC_VERIF, 8'h20, 16'h0002);
        dwr(16'hA5A5);
        dwr(16'h1234);
        stat(s);
        chk(32'(s[15:0]), 32'h000021FF);
        // plain reads need no enable; the third word shows the erase
        cmd(FC_READ, 8'h20, 16'h0003);
        drd(16'hA5A5);
        drd(16'h5A5A);
        drd(NV_ERASED);
        stat(s);
        chk(32'(s[15:0]), 32'h00000300);
        cmd(FC_READ, 8'h00, 16'h0001);
        host.bus(1'b0, ADR_DATA, 32'h00000000, r);
        stat(s);
        chk(32'(s[15:0]), 32'h00000100);
        // a stalled session times out and reports words done
        cmd(FC_READ, 8'h30, 16'h0002);
        host.bus(1'b0, ADR_DATA, 32'h00000000, r);
        repeat (XFC + 8) @(posedge clk_sys);
        stat(s);
        chk(32'(s[15:0]), 32'h00000180);
        cmd(FC_WREN, 8'h00, 16'h0000);
        cmd(FC_WRITE, 8'h3E, 16'h0002);
        dwr(16'h0001);
        repeat (XFC + 8) @(posedge clk_sys);
        stat(s);
        chk(32'(s[17:0]), 32'h00020180);
        cmd(FC_WRDIS, 8'h00, 16'h0000);
        // watchdog codes leave the last result in place
        cmd(8'hFE, 8'h00, 16'h0000);
        cmd(FC_WD_ON, 8'h00, 16'h0000);
        stat(s);
        chk(32'(s[18:0]), 32'h00040040);
        repeat (150) @(posedge clk_sys);
        cmd(FC_WD_RF, 8'h00, 16'h0000);
        repeat (150) @(posedge clk_sys);
        chk(32'(bites), 32'h00000000);
        repeat (100) @(posedge clk_sys);
        chk(32'(bites), 32'h00000001);
        stat(s);
        chk(32'(s[18:0]), 32'h00000000);
        cmd(FC_WD_ON, 8'h00, 16'h0000);
        cmd(FC_WD_OF, 8'h00, 16'h0000);
        repeat (300) @(posedge clk_sys);
        chk(32'(bites), 32'h00000001);
        // contents outlive a reset in mid-run
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        cmd(FC_READ, 8'h21, 16'h0001);
        drd(16'h5A5A);
        conclude();
    end
endmodule : nvws_test
